// File: design/gpp_pkg.sv
`default_nettype none

package gpp_pkg;

	// ------------------------------------------------------------
	// Bus geometry and register indexes (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam int       AVL_AW         = 6;
	localparam int       AVL_DW         = 32;
	localparam int       AVL_BEW        = 4;
	localparam int       IDX_W          = 4;
	localparam int       IDX_LSB        = 2;
	localparam logic [3:0] IDX_G1_LATCH = 4'h1;
	localparam logic [3:0] IDX_G2_LATCH = 4'h2;
	localparam logic [3:0] IDX_G3_LATCH = 4'h3;
	localparam logic [3:0] IDX_CTRL     = 4'h8;
	localparam logic [3:0] IDX_G1_DIR   = 4'h9;
	localparam logic [3:0] IDX_G3_DIR   = 4'hA;
	localparam logic [3:0] IDX_G2_PIN   = 4'hD;
	localparam logic [3:0] IDX_CONV     = 4'hE;

	// ------------------------------------------------------------
	// Widths and field positions
	// ------------------------------------------------------------
	localparam int G1_W            = 7;
	localparam int G2_W            = 3;
	localparam int G3_W            = 8;
	localparam int SEL_W           = 3;
	localparam int CTRL_IRQ0_BIT   = 0;
	localparam int CTRL_DUAL_BIT   = 1;
	localparam int CONV_SEL_LSB    = 0;
	localparam int CONV_AN_DIS_BIT = 4;
	localparam int G1_DIV_PIN      = 2;
	localparam int AN_FIRST_PIN    = 2;
	localparam logic [2:0] AN_LAST_CH = 3'h5;
	localparam int KEY_LSB         = 4;
	localparam int KEY_W           = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [6:0]  G1_LATCH_RST = 7'h00;
	localparam logic [6:0]  G1_DIR_RST   = 7'h00;
	localparam logic [2:0]  G2_LATCH_RST = 3'h7;
	localparam logic [7:0]  G3_LATCH_RST = 8'h00;
	localparam logic [7:0]  G3_DIR_RST   = 8'h00;
	localparam logic        AN_DIS_RST   = 1'b1;
	localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} gpp_bus_st_t;

	typedef struct packed {
		logic irq_zero;
		logic irq_one;
		logic irq_five;
	} gpp_evt_t;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [AVL_AW-1:0] addr;
		logic [AVL_DW-1:0] wdata;
		logic [AVL_BEW-1:0] be;
	} gpp_avl_req_t;

	typedef struct packed {
		gpp_bus_st_t       bus;
		logic [AVL_DW-1:0] rdata;
		logic [G1_W-1:0]   g1_latch;
		logic [G1_W-1:0]   g1_dir;
		logic [G2_W-1:0]   g2_latch;
		logic [G3_W-1:0]   g3_latch;
		logic [G3_W-1:0]   g3_dir;
		logic              an_dis;
		logic [SEL_W-1:0]  chan_sel;
		logic              irq0_sel;
		logic              dual_clk;
		logic [1:0]        g1_prev;
		logic              g2_prev;
		gpp_evt_t          evt;
		logic [KEY_W-1:0]  key_wake;
	} gpp_state_t;

	localparam gpp_state_t ST_RST = '{
		bus: BUS_IDLE, rdata: RDATA_RST,
		g1_latch: G1_LATCH_RST, g1_dir: G1_DIR_RST,
		g2_latch: G2_LATCH_RST,
		g3_latch: G3_LATCH_RST, g3_dir: G3_DIR_RST,
		an_dis: AN_DIS_RST, chan_sel: 3'h0,
		irq0_sel: 1'b0, dual_clk: 1'b0,
		g1_prev: 2'h0, g2_prev: 1'b0,
		evt: 3'h0, key_wake: 4'h0
	};

endpackage

`default_nettype wire

// File: design/gpp_ports.sv
// How it works
// - Group one has seven pins, per-bit direction, 1 output, reset to input.
// - Group one output latch clears to zero on reset.
// - Group one pin 1 edges still raise its event while driven.
// - Group one pin 0 is plain I/O or interrupt input; reset plain.
// - Group two latch resets to ones; software keeps inputs at one.
// - Dual-clock mode hands group two pins 1 and 2 to the resonator.
// - Falling edge on group two pin 0 raises its event even as output.
// - Group two latch read returns latch; pin-level read returns pins.
// - Group two reads show bits 7 to 3 undefined; here they read zero.
// - In STOP mode group two pin 0 never drives.
// - Group three: eight pins, dir and latch zero, analog off at reset.
// - Analog enabled: selected group three pin is analog, never driven.
// - Group three pin with direction one drives its latch value.
// - Analog-selected and output-mode pins read their latch; other input pins read the pin.
// - Writes never drive latch data onto analog-selected pins.
// - Input-mode bits other than the analog-selected pin read the pin, so read-modify-write may alter latches.
//
// Decided for this implementation: the Avalon-MM register port.
`default_nettype none

module gpp_ports (
	// Clock and reset
	input  wire logic                       SYS_CLK_I,
	input  wire logic                       SYS_RST_I,
	// Avalon-MM slave
	input  wire logic [gpp_pkg::AVL_AW-1:0] AVS_ADDRESS_I,
	input  wire logic                       AVS_READ_I,
	input  wire logic                       AVS_WRITE_I,
	input  wire logic [gpp_pkg::AVL_DW-1:0] AVS_WRITEDATA_I,
	input  wire logic [gpp_pkg::AVL_BEW-1:0] AVS_BYTEENABLE_I,
	output logic      [gpp_pkg::AVL_DW-1:0] AVS_READDATA_O,
	output logic                            AVS_WAITREQUEST_O,
	// Group one pins
	input  wire logic [gpp_pkg::G1_W-1:0]   G1_PIN_I,
	output logic      [gpp_pkg::G1_W-1:0]   G1_PIN_O,
	output logic      [gpp_pkg::G1_W-1:0]   G1_PIN_OE_O,
	// Group two pins
	input  wire logic [gpp_pkg::G2_W-1:0]   G2_PIN_I,
	output logic      [gpp_pkg::G2_W-1:0]   G2_PIN_O,
	output logic      [gpp_pkg::G2_W-1:0]   G2_PIN_OE_O,
	// Group three pins
	input  wire logic [gpp_pkg::G3_W-1:0]   G3_PIN_I,
	output logic      [gpp_pkg::G3_W-1:0]   G3_PIN_O,
	output logic      [gpp_pkg::G3_W-1:0]   G3_PIN_OE_O,
	// Shared functions and system state
	input  wire logic                       DIV_OUT_I,
	input  wire logic                       DIV_EN_I,
	input  wire logic                       STOP_MODE_I,
	output gpp_pkg::gpp_evt_t               EVENTS_O,
	output logic      [gpp_pkg::KEY_W-1:0]  KEY_WAKE_O,
	output logic                            AN_DIS_O,
	output logic      [gpp_pkg::SEL_W-1:0]  CHAN_SEL_O,
	output logic                            DUAL_CLK_O
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Channel n makes pin n + 2 analog; six and seven pick none
	function automatic logic [7:0] an_mask_f(
		input logic                      dis,
		input logic [gpp_pkg::SEL_W-1:0] sel
	);
		logic [7:0] m;
		m = 8'h00;
		if (!dis && sel <= gpp_pkg::AN_LAST_CH)
		begin
			m[sel + 3'(gpp_pkg::AN_FIRST_PIN)] = 1'b1;
		end
		return m;
	endfunction

	// Output-mode and analog bits show the latch, the rest the pin
	function automatic logic [7:0] rd_mix_f(
		input logic [7:0] latch,
		input logic [7:0] dir,
		input logic [7:0] pin
	);
		return (latch & dir) | (pin & ~dir);
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	gpp_pkg::gpp_state_t  s_q;
	gpp_pkg::gpp_state_t  s_d;
	gpp_pkg::gpp_avl_req_t req;
	logic [gpp_pkg::IDX_W-1:0] idx;
	logic [7:0]           an_mask;
	logic                 bus_req;

	assign req = '{
		read: AVS_READ_I, write: AVS_WRITE_I, addr: AVS_ADDRESS_I,
		wdata: AVS_WRITEDATA_I, be: AVS_BYTEENABLE_I
	};

	// Byte address, word registers: bits 1 and 0 ignored
	assign idx = req.addr[gpp_pkg::IDX_LSB +: gpp_pkg::IDX_W];
	assign bus_req = req.read | req.write;
	assign an_mask = an_mask_f(s_q.an_dis, s_q.chan_sel);

	always_comb
	begin
		logic [7:0] rd;
		logic [7:0] wd;
		rd = 8'h00;
		wd = req.wdata[7:0];
		s_d = s_q;

		// Edge detection stays live whatever the pin direction
		s_d.g1_prev = G1_PIN_I[1:0];
		s_d.g2_prev = G2_PIN_I[0];
		s_d.evt.irq_one = G1_PIN_I[1] ^ s_q.g1_prev[1];
		s_d.evt.irq_zero = s_q.irq0_sel & s_q.g1_prev[0]
			& ~G1_PIN_I[0];
		s_d.evt.irq_five = s_q.g2_prev & ~G2_PIN_I[0];
		s_d.key_wake = G3_PIN_I[gpp_pkg::KEY_LSB +: gpp_pkg::KEY_W]
			& ~s_q.g3_dir[gpp_pkg::KEY_LSB +: gpp_pkg::KEY_W];

		// Read value, unmapped indexes answer zero
		case (idx)
			gpp_pkg::IDX_G1_LATCH:
				rd = rd_mix_f({1'b0, s_q.g1_latch},
					{1'b0, s_q.g1_dir},
					{1'b0, G1_PIN_I});
			gpp_pkg::IDX_G2_LATCH:
				rd = {5'h00, s_q.g2_latch};
			gpp_pkg::IDX_G3_LATCH:
				rd = rd_mix_f(s_q.g3_latch, s_q.g3_dir | an_mask,
					G3_PIN_I);
			gpp_pkg::IDX_G1_DIR:
				rd = {1'b0, s_q.g1_dir};
			gpp_pkg::IDX_G3_DIR:
				rd = s_q.g3_dir;
			gpp_pkg::IDX_G2_PIN:
				rd = {5'h00, G2_PIN_I};
			gpp_pkg::IDX_CONV:
			begin
				rd[gpp_pkg::CONV_AN_DIS_BIT] = s_q.an_dis;
				rd[gpp_pkg::CONV_SEL_LSB +: gpp_pkg::SEL_W] = s_q.chan_sel;
			end
			gpp_pkg::IDX_CTRL:
			begin
				rd[gpp_pkg::CTRL_IRQ0_BIT] = s_q.irq0_sel;
				rd[gpp_pkg::CTRL_DUAL_BIT] = s_q.dual_clk;
			end
			default:
				rd = 8'h00;
		endcase

		// One wait cycle, then the request completes
		case (s_q.bus)
			gpp_pkg::BUS_IDLE:
			begin
				if (bus_req)
				begin
					s_d.bus = gpp_pkg::BUS_ACK;
					s_d.rdata = {24'h00_0000, rd};
				end
			end
			gpp_pkg::BUS_ACK:
			begin
				// Write lands only while the master still holds it
				s_d.bus = gpp_pkg::BUS_IDLE;
				if (req.write && req.be[0])
				begin
					case (idx)
						gpp_pkg::IDX_G1_LATCH:
							s_d.g1_latch = wd[6:0];
						gpp_pkg::IDX_G1_DIR:
							s_d.g1_dir = wd[6:0];
						gpp_pkg::IDX_G2_LATCH:
							s_d.g2_latch = wd[2:0];
						gpp_pkg::IDX_G3_LATCH:
							s_d.g3_latch = wd;
						gpp_pkg::IDX_G3_DIR:
							s_d.g3_dir = wd;
						gpp_pkg::IDX_CONV:
						begin
							s_d.an_dis = wd[gpp_pkg::CONV_AN_DIS_BIT];
							s_d.chan_sel =
								wd[gpp_pkg::CONV_SEL_LSB +: gpp_pkg::SEL_W];
						end
						gpp_pkg::IDX_CTRL:
						begin
							s_d.irq0_sel = wd[gpp_pkg::CTRL_IRQ0_BIT];
							s_d.dual_clk = wd[gpp_pkg::CTRL_DUAL_BIT];
						end
						default:
							s_d.bus = gpp_pkg::BUS_IDLE;
					endcase
				end
			end
			default:
				s_d.bus = gpp_pkg::BUS_IDLE;
		endcase
	end

	// Synchronous reset: the whole state struct reloads at once
	always_ff @(posedge SYS_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			s_q <= gpp_pkg::ST_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------
	// Combinational, so an idle slave stalls a new request at once
	assign AVS_WAITREQUEST_O = bus_req & (s_q.bus == gpp_pkg::BUS_IDLE);
	assign AVS_READDATA_O    = s_q.rdata;

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	// Divider gated by the latch, so the latch must sit at one first
	always_comb
	begin
		G1_PIN_O = s_q.g1_latch;
		if (DIV_EN_I)
		begin
			G1_PIN_O[gpp_pkg::G1_DIV_PIN] =
				s_q.g1_latch[gpp_pkg::G1_DIV_PIN] & DIV_OUT_I;
		end
	end
	assign G1_PIN_OE_O = s_q.g1_dir;

	// Group two sinks only: a latch at one leaves the pin free
	assign G2_PIN_O       = s_q.g2_latch;
	assign G2_PIN_OE_O = ~s_q.g2_latch
		& {~s_q.dual_clk, ~s_q.dual_clk, ~STOP_MODE_I};

	// Analog pins stay released even when their direction bit is set
	assign G3_PIN_O    = s_q.g3_latch;
	assign G3_PIN_OE_O = s_q.g3_dir & ~an_mask;

	assign EVENTS_O   = s_q.evt;
	assign KEY_WAKE_O = s_q.key_wake;
	assign AN_DIS_O   = s_q.an_dis;
	assign CHAN_SEL_O = s_q.chan_sel;
	assign DUAL_CLK_O = s_q.dual_clk;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	sequence s_req_wait;
		bus_req && AVS_WAITREQUEST_O;
	endsequence

	sequence s_read_done(logic [3:0] i);
		AVS_READ_I && !AVS_WAITREQUEST_O && idx == i;
	endsequence

	sequence s_write_done(logic [3:0] i);
		AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0] && idx == i;
	endsequence

	// Reset values

	a_reset_g1_input: assert property (
		$past(SYS_RST_I) |-> G1_PIN_OE_O == 7'h00
			&& G1_PIN_O == 7'h00)
		else $error("group one not input and zero after reset");

	a_reset_g2_ones: assert property (
		$past(SYS_RST_I) |-> G2_PIN_O == 3'h7 && G2_PIN_OE_O == 3'h0)
		else $error("group two latch not all ones after reset");

	a_reset_g3_digital: assert property (
		$past(SYS_RST_I) |-> AN_DIS_O && G3_PIN_OE_O == 8'h00
			&& G3_PIN_O == 8'h00)
		else $error("group three not digital input after reset");

	// Pin events
	a_irq1_any_edge: assert property (
		!$past(SYS_RST_I) && $changed(G1_PIN_I[1])
			|=> EVENTS_O.irq_one)
		else $error("pin one edge did not raise event");

	a_irq0_gated: assert property (
		EVENTS_O.irq_zero |-> $past(s_q.irq0_sel)
			&& $past(G1_PIN_I[0], 2) && !$past(G1_PIN_I[0]))
		else $error("pin zero event without select or fall");

	a_irq5_fall: assert property (
		!$past(SYS_RST_I) && $fell(G2_PIN_I[0]) |=> EVENTS_O.irq_five)
		else $error("group two pin zero fall lost");

	// Pin drive
	a_stop_hiz: assert property (
		STOP_MODE_I |-> !G2_PIN_OE_O[0])
		else $error("group two pin zero driven in stop");

	a_dual_clock_pins: assert property (
		DUAL_CLK_O |-> G2_PIN_OE_O[2:1] == 2'h0)
		else $error("resonator pins driven");

	a_analog_no_drive: assert property (
		!AN_DIS_O && CHAN_SEL_O <= 3'h5
			|-> !G3_PIN_OE_O[CHAN_SEL_O + 3'h2])
		else $error("analog pin driven");

	a_g3_drive_latch: assert property (
		(G3_PIN_OE_O & ~s_q.g3_dir) == 8'h00
			&& (s_q.g3_dir & ~G3_PIN_OE_O) == (AN_DIS_O ? 8'h00
				: s_q.g3_dir & (8'h04 << CHAN_SEL_O))
			&& G3_PIN_O == s_q.g3_latch)
		else $error("group three drive mismatch");

	// Register bus
	a_bus_one_wait: assert property (
		s_req_wait |=> !AVS_WAITREQUEST_O)
		else $error("bus answer not after one wait cycle");

	a_g2_pin_read: assert property (
		s_read_done(gpp_pkg::IDX_G2_PIN)
			|-> AVS_READDATA_O == {29'h0, $past(G2_PIN_I)})
		else $error("group two pin read wrong");

	a_g1_read_mix: assert property (
		s_read_done(gpp_pkg::IDX_G1_LATCH)
			|-> AVS_READDATA_O[6:0] == (($past(s_q.g1_latch)
				& $past(s_q.g1_dir)) | ($past(G1_PIN_I)
				& ~$past(s_q.g1_dir))) && !AVS_READDATA_O[7])
		else $error("group one read not pin for inputs");

	a_g1_dir_lands: assert property (
		s_write_done(gpp_pkg::IDX_G1_DIR)
			|=> G1_PIN_OE_O == $past(AVS_WRITEDATA_I[6:0]))
		else $error("group one direction write lost");

	a_g3_dir_lands: assert property (
		s_write_done(gpp_pkg::IDX_G3_DIR) && AN_DIS_O
			|=> G3_PIN_OE_O == $past(AVS_WRITEDATA_I[7:0]))
		else $error("group three direction write lost");

	a_lane_off_drop: assert property (
		AVS_WRITE_I && !AVS_WAITREQUEST_O && !AVS_BYTEENABLE_I[0]
			|=> $stable(s_q.g1_latch) && $stable(s_q.g1_dir)
				&& $stable(s_q.g2_latch) && $stable(s_q.g3_latch)
				&& $stable(s_q.g3_dir) && $stable(s_q.an_dis))
		else $error("write with lane zero off changed state");

	a_g2_latch_read: assert property (
		s_read_done(gpp_pkg::IDX_G2_LATCH)
			|-> AVS_READDATA_O[2:0] == $past(G2_PIN_O))
		else $error("group two latch read wrong");

	a_g2_upper_zero: assert property (
		AVS_READ_I && !AVS_WAITREQUEST_O
			&& (idx == gpp_pkg::IDX_G2_LATCH
				|| idx == gpp_pkg::IDX_G2_PIN)
			|-> AVS_READDATA_O[31:3] == 29'h0)
		else $error("group two upper read bits not zero");

	a_g3_analog_read: assert property (
		s_read_done(gpp_pkg::IDX_G3_LATCH) ##0 !$past(AN_DIS_O)
			|-> ((AVS_READDATA_O[7:0] ^ $past(G3_PIN_O))
				& (8'h04 << $past(CHAN_SEL_O))) == 8'h00)
		else $error("analog pin read not latch");

endmodule // gpp_ports

`default_nettype wire

// File: test/gpp_pin_model.sv
`default_nettype none

module gpp_pin_model (
	// Device drive
	input  wire logic [6:0] g1_o_i,
	input  wire logic [6:0] g1_oe_i,
	input  wire logic [2:0] g2_o_i,
	input  wire logic [2:0] g2_oe_i,
	input  wire logic [7:0] g3_o_i,
	input  wire logic [7:0] g3_oe_i,
	// Board-side levels
	input  wire logic [6:0] g1_ext_i,
	input  wire logic [7:0] g3_ext_i,
	// Resolved pin levels
	output logic      [6:0] g1_pin_o,
	output logic      [2:0] g2_pin_o,
	output logic      [7:0] g3_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Released group two pins float up to the board pull-up
	assign g2_pin_o = (g2_oe_i & g2_o_i) | ~g2_oe_i;
	assign g1_pin_o = (g1_oe_i & g1_o_i) | (~g1_oe_i & g1_ext_i);
	// Analog-selected pins are never driven, so the board level wins
	assign g3_pin_o = (g3_oe_i & g3_o_i) | (~g3_oe_i & g3_ext_i);
endmodule // gpp_pin_model

`default_nettype wire

// File: test/three_group_parallel_io_ports_tb.sv
`default_nettype none

module three_group_parallel_io_ports_tb;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic       wr;
		logic [3:0] idx;
		logic [7:0] data;
		logic [7:0] exp;
	} gpp_row_t;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [5:0]        addr = 6'h00;
	logic              rd = 1'b0;
	logic              wr = 1'b0;
	logic [31:0]       wdata = 32'h0000_0000;
	logic [3:0]        be = 4'hF;
	logic [31:0]       readdata;
	logic              waitreq;
	logic [6:0]        g1_pin, g1_o, g1_oe;
	logic [2:0]        g2_pin, g2_o, g2_oe;
	logic [7:0]        g3_pin, g3_o, g3_oe;
	logic              div_out = 1'b0;
	logic              div_en = 1'b0;
	logic              stop = 1'b0;
	gpp_pkg::gpp_evt_t evts;
	logic [3:0]        key_wake;
	logic              an_dis;
	logic [2:0]        chan_sel;
	logic              dual_clk;
	logic [31:0]       q;
	int                miscompares = 0;
	int                cmp_count = 0;
	int                n0 = 0;
	int                n1 = 0;
	int                n5 = 0;

	gpp_row_t rows [22] = '{
		'{1'b0, 4'h1, 8'h00, 8'h55},
		'{1'b0, 4'h9, 8'h00, 8'h00},
		'{1'b0, 4'h2, 8'h00, 8'h07},
		'{1'b0, 4'hD, 8'h00, 8'h07},
		'{1'b0, 4'h3, 8'h00, 8'h3C},
		'{1'b0, 4'hA, 8'h00, 8'h00},
		'{1'b0, 4'hE, 8'h00, 8'h10},
		'{1'b0, 4'h8, 8'h00, 8'h00},
		'{1'b1, 4'h1, 8'hFE, 8'h00},
		'{1'b1, 4'h9, 8'h8F, 8'h00},
		'{1'b0, 4'h9, 8'h00, 8'h0F},
		'{1'b0, 4'h1, 8'h00, 8'h5E},
		'{1'b1, 4'h3, 8'hA5, 8'h00},
		'{1'b1, 4'hA, 8'hF0, 8'h00},
		'{1'b0, 4'h3, 8'h00, 8'hAC},
		'{1'b1, 4'hE, 8'h01, 8'h00},
		'{1'b0, 4'h3, 8'h00, 8'hA4},
		'{1'b1, 4'h5, 8'hFF, 8'h00},
		'{1'b0, 4'h5, 8'h00, 8'h00},
		'{1'b1, 4'h2, 8'h06, 8'h00},
		'{1'b0, 4'h2, 8'h00, 8'h06},
		'{1'b0, 4'hD, 8'h00, 8'h06}
	};

	always #4 clk = ~clk;

	gpp_ports uut (
		.SYS_CLK_I(clk), .SYS_RST_I(rst),
		.AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
		.AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
		.AVS_READDATA_O(readdata), .AVS_WAITREQUEST_O(waitreq),
		.G1_PIN_I(g1_pin), .G1_PIN_O(g1_o), .G1_PIN_OE_O(g1_oe),
		.G2_PIN_I(g2_pin), .G2_PIN_O(g2_o), .G2_PIN_OE_O(g2_oe),
		.G3_PIN_I(g3_pin), .G3_PIN_O(g3_o), .G3_PIN_OE_O(g3_oe),
		.DIV_OUT_I(div_out), .DIV_EN_I(div_en), .STOP_MODE_I(stop),
		.EVENTS_O(evts), .KEY_WAKE_O(key_wake), .AN_DIS_O(an_dis),
		.CHAN_SEL_O(chan_sel), .DUAL_CLK_O(dual_clk)
	);

	gpp_pin_model pins (
		.g1_o_i(g1_o), .g1_oe_i(g1_oe), .g2_o_i(g2_o),
		.g2_oe_i(g2_oe), .g3_o_i(g3_o), .g3_oe_i(g3_oe),
		.g1_ext_i(7'h55), .g3_ext_i(8'h3C),
		.g1_pin_o(g1_pin), .g2_pin_o(g2_pin), .g3_pin_o(g3_pin)
	);

	always @(posedge clk)
	begin
		if (evts.irq_zero === 1'b1)
			n0++;
		if (evts.irq_one === 1'b1)
			n1++;
		if (evts.irq_five === 1'b1)
			n5++;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic wrap_up;
		if (miscompares == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Holds the request until waitrequest is sampled low
	task automatic avl(input logic w, input logic [3:0] idx,
		input logic [7:0] d, input logic [3:0] b);
		int n;
		n = 0;
		@(posedge clk);
		addr  <= {idx, 2'b00};
		wdata <= {24'h00_0000, d};
		be    <= b;
		rd    <= ~w;
		wr    <= w;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitreq !== 1'b0 && n < 50);
		q = readdata;
		if (n >= 50)
		begin
			miscompares++;
			$display("wrong value at %0t: bus request not answered", $time);
			wrap_up();
		end
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic rst_chk;
		chk({5'h00, g2_o}, 8'h07);
		chk({5'h00, g2_oe}, 8'h00);
		chk({1'b0, g1_oe}, 8'h00);
		chk(g3_oe, 8'h00);
		chk({7'h00, an_dis}, 8'h01);
	endtask

	initial
	begin
		#50000;
		miscompares++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		settle();
		rst_chk();
		foreach (rows[i])
		begin
			avl(rows[i].wr, rows[i].idx, rows[i].data, 4'hF);
			if (!rows[i].wr)
				chk(q[7:0], rows[i].exp);
		end
		settle();
		chk({5'h00, chan_sel}, 8'h01);
		chk(8'(n5), 8'h01);
		chk(8'(n1), 8'h01);
		avl(1'b1, 4'h1, 8'hFD, 4'hF);
		avl(1'b1, 4'h1, 8'hFC, 4'hF);
		settle();
		chk(8'(n1), 8'h02);
		chk(8'(n0), 8'h00);
		avl(1'b1, 4'h8, 8'h01, 4'hF);
		avl(1'b1, 4'h1, 8'hFD, 4'hF);
		avl(1'b1, 4'h1, 8'hFC, 4'hF);
		settle();
		chk(8'(n0), 8'h01);
		// Byte lane zero off: the write must be dropped
		avl(1'b1, 4'h1, 8'hFF, 4'h0);
		avl(1'b0, 4'h1, 8'h00, 4'hF);
		chk(q[7:0], 8'h5C);
		avl(1'b1, 4'hA, 8'hF8, 4'hF);
		settle();
		chk(g3_oe, 8'hF0);
		chk(g3_o, 8'hA5);
		@(posedge clk);
		stop <= 1'b1;
		settle();
		chk({5'h00, g2_oe}, 8'h00);
		@(posedge clk);
		stop <= 1'b0;
		avl(1'b1, 4'h2, 8'h00, 4'hF);
		avl(1'b1, 4'h8, 8'h02, 4'hF);
		settle();
		chk({5'h00, g2_oe}, 8'h01);
		chk({7'h00, dual_clk}, 8'h01);
		@(posedge clk);
		div_en <= 1'b1;
		settle();
		chk({7'h00, g1_o[2]}, 8'h00);
		@(posedge clk);
		div_out <= 1'b1;
		settle();
		chk({7'h00, g1_o[2]}, 8'h01);
		avl(1'b1, 4'hE, 8'h10, 4'hF);
		avl(1'b1, 4'hA, 8'h00, 4'hF);
		settle();
		chk({4'h0, key_wake}, 8'h03);
		avl(1'b0, 4'h3, 8'h00, 4'hF);
		chk(q[7:0], 8'h3C);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		settle();
		rst_chk();
		avl(1'b1, 4'h9, 8'h7F, 4'hF);
		avl(1'b0, 4'h1, 8'h00, 4'hF);
		chk(q[7:0], 8'h00);
		wrap_up();
	end
endmodule // three_group_parallel_io_ports_tb

`default_nettype wire
